// ---- scd_pkg.sv ----
// Shared constants and types for the command decode and bank state block
package scd_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int CNT_W         = 8;
   localparam int BA_W          = 3;
   localparam int NBANK         = 8;
   localparam int AP_BIT        = 10;
   localparam int BURST_LEN     = 4;

   // Plain defaults; the real figures depend on speed grade and density
   localparam int T_RP_NS   = 15;
   localparam int T_RCD_NS  = 15;
   localparam int T_WR_NS   = 15;
   localparam int T_RFC_NS  = 105;
   localparam int T_XSNR_NS = 115;
   localparam int T_MRD_CK  = 2;

   // Least times round up to whole cycles
   localparam logic [CNT_W-1:0] RP_CNT   =
      CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RCD_CNT  =
      CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_CNT   =
      CNT_W'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RFC_CNT  =
      CNT_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] XSNR_CNT =
      CNT_W'((T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MRD_CNT  = CNT_W'(T_MRD_CK);
   // Two data beats per clock
   localparam logic [CNT_W-1:0] BURST_CNT = CNT_W'(BURST_LEN / 2);

   localparam logic RST_CKE_PREV = 1'b0;
   localparam logic RST_ILLEGAL  = 1'b0;
   localparam logic RST_ODT_EN   = 1'b0;

   typedef enum logic [3:0] {
      CMD_DESELECT,
      CMD_NOP,
      CMD_MODE_LOAD,
      CMD_REFRESH,
      CMD_SELF_REF,
      CMD_PRECHARGE,
      CMD_PRECHARGE_ALL,
      CMD_ACTIVATE,
      CMD_READ,
      CMD_READ_AP,
      CMD_WRITE,
      CMD_WRITE_AP,
      CMD_PD_ENTRY,
      CMD_CKE_EXIT,
      CMD_HOLD,
      CMD_INVALID
   } scd_cmd_t;

   typedef enum logic [2:0] {
      BANK_IDLE,
      BANK_ACTIVATING,
      BANK_ACTIVE,
      BANK_READ,
      BANK_WRITE,
      BANK_READ_AP,
      BANK_WRITE_AP,
      BANK_PRECHARGING
   } scd_bank_t;

   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_REFRESHING,
      MODE_MRD,
      MODE_SELF_REF,
      MODE_XSNR,
      MODE_PDOWN
   } scd_mode_t;

endpackage

// ---- scd_cmd_if.sv ----
// Decoded command carried from the pin decoder to the bank tracker
interface scd_cmd_if #(
   parameter int ADDR_W = 14
);
   scd_pkg::scd_cmd_t              cmd;
   logic [scd_pkg::BA_W-1:0]       bank;
   logic [ADDR_W-1:0]              addr;

   modport dec  (output cmd, output bank, output addr);
   modport core (input cmd, input bank, input addr);
endinterface

// ---- scd_decode.sv ----
// Pin-level command decoder: strobes and clock enable to one command code
module scd_decode #(
   parameter int ADDR_W = 14
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic                        cke,
   input  wire logic                        cs_b,
   input  wire logic                        ras_b,
   input  wire logic                        cas_b,
   input  wire logic                        we_b,
   input  wire logic [scd_pkg::BA_W-1:0]    ba,
   input  wire logic [ADDR_W-1:0]           addr,
   input  wire logic                        use_ba2,
   scd_cmd_if.dec                           cmd_o
);
   import scd_pkg::*;

   typedef struct packed {
      logic cke_prev;
   } scd_dec_state_t;

   scd_dec_state_t st;
   scd_dec_state_t next_st;
   logic           quiet;
   logic [2:0]     strobes;

   always_comb begin
      next_st          = st;
      next_st.cke_prev = cke;
      strobes          = {ras_b, cas_b, we_b};
      quiet            = cs_b | (strobes == 3'h7);
      // R3: bank select width
      cmd_o.bank       = use_ba2 ? ba : {1'b0, ba[BA_W-2:0]};
      cmd_o.addr       = addr;
      cmd_o.cmd        = CMD_INVALID;
      // R1: strobes and clock enable only
      if (st.cke_prev && cke) begin
         // R18: bank commands need both samples high
         if (cs_b) begin
            cmd_o.cmd = CMD_DESELECT;
         end else begin
            // R12: deselect and no-operation
            case (strobes)
               3'h7: cmd_o.cmd = CMD_NOP;
               // R4: mode load
               3'h0: cmd_o.cmd = CMD_MODE_LOAD;
               3'h1: cmd_o.cmd = CMD_REFRESH;
               // R10: single or all precharge
               3'h2: cmd_o.cmd = addr[AP_BIT] ? CMD_PRECHARGE_ALL : CMD_PRECHARGE;
               // R11: activate
               3'h3: cmd_o.cmd = CMD_ACTIVATE;
               // R9: write with optional auto precharge
               3'h4: cmd_o.cmd = addr[AP_BIT] ? CMD_WRITE_AP : CMD_WRITE;
               // R8: read with optional auto precharge
               3'h5: cmd_o.cmd = addr[AP_BIT] ? CMD_READ_AP : CMD_READ;
               default: cmd_o.cmd = CMD_INVALID;
            endcase
         end
      end else if (st.cke_prev && !cke) begin
         // R5: refresh encoding with falling enable
         if (!cs_b && strobes == 3'h1) begin
            cmd_o.cmd = CMD_SELF_REF;
         // R6: power-down entry
         end else if (quiet) begin
            cmd_o.cmd = CMD_PD_ENTRY;
         end
      end else if (!st.cke_prev && cke) begin
         // R5: exit on rising enable with quiet bus
         if (quiet) begin
            cmd_o.cmd = CMD_CKE_EXIT;
         end
      end else begin
         cmd_o.cmd = CMD_HOLD;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st.cke_prev <= RST_CKE_PREV;
      end else begin
         st <= next_st;
      end
   end

endmodule

// ---- scd_top.sv ----
// Command decode and per-bank state tracking for a DDR2 memory device
// Summary of operation
// R1: Commands come from strobes and CKE only
// R2: ODT ignored by decode, off in self refresh
// R3: Bank address picks bank; BA2 optional
// R4: Mode load picks register by bank
// R5: Self refresh entry and exit by CKE
// R6: Power-down by CKE with quiet bus
// R7: Controller bounds power-down time for refresh
// R8: Read decode, A10 selects auto precharge
// R9: Write decode, A10 selects auto precharge
// R10: Precharge one bank or all by A10
// R11: Activate opens row in idle bank only
// R12: Deselect and NOP change nothing
// R13: Idle after precharge time and read end
// R14: Row active accepts read, write, precharge
// R15: Read burst accepts read, write, precharge; the code rejects all three until the burst ends
// R16: Write burst accepts write, read, precharge; the code rejects all three until the burst ends
// R17: Four-beat bursts never cut short
// R18: Bank rules only with CKE high twice
// R19: Controller idles transitional banks
// R20: Unused column bits are ignored
// R21: Refresh, mode load only all idle
// R22: Unlisted combinations are illegal
// R23: Flag illegal command, keep bank state
module scd_top #(
   parameter int ADDR_W = 14,
   parameter int COL_W  = 10
) (
   input  wire logic                                    clk,
   input  wire logic                                    rst_b,
   input  wire logic                                    cke,
   input  wire logic                                    cs_b,
   input  wire logic                                    ras_b,
   input  wire logic                                    cas_b,
   input  wire logic                                    we_b,
   input  wire logic [scd_pkg::BA_W-1:0]                ba,
   input  wire logic [ADDR_W-1:0]                       addr,
   input  wire logic                                    odt,
   input  wire logic                                    use_ba2,
   output logic      [3:0]                              cmd_code,
   output logic      [scd_pkg::BA_W-1:0]                cmd_bank,
   output logic      [ADDR_W-1:0]                       cmd_addr,
   output logic      [scd_pkg::BA_W-1:0]                mode_sel,
   output logic                                         illegal,
   output logic                                         odt_en,
   output logic                                         self_refresh,
   output logic                                         power_down,
   output logic                                         refreshing,
   output logic      [scd_pkg::NBANK-1:0][2:0]          bank_state
);
   import scd_pkg::*;

   typedef struct packed {
      scd_mode_t                          mode;
      logic [CNT_W-1:0]                   gcnt;
      scd_bank_t [NBANK-1:0]              bst;
      logic [NBANK-1:0][CNT_W-1:0]        bcnt;
      scd_cmd_t                           cmd;
      logic [BA_W-1:0]                    bank;
      logic [ADDR_W-1:0]                  addr;
      logic [BA_W-1:0]                    mode_sel;
      logic                               illegal;
      logic                               odt_en;
      // Mode levels kept in flops so the outputs carry no decode
      logic [2:0]                         lvl;
   } scd_state_t;

   scd_state_t st;
   scd_state_t next_st;

   scd_cmd_if #(.ADDR_W(ADDR_W)) dcmd ();

   scd_decode #(.ADDR_W(ADDR_W)) u_decode (
      .clk     (clk),
      .rst_b   (rst_b),
      .cke     (cke),
      .cs_b    (cs_b),
      .ras_b   (ras_b),
      .cas_b   (cas_b),
      .we_b    (we_b),
      .ba      (ba),
      .addr    (addr),
      .use_ba2 (use_ba2),
      .cmd_o   (dcmd)
   );

   // Banks that may take a column access or a precharge this cycle
   function automatic logic can_access(input scd_bank_t s);
      return s == BANK_ACTIVE;
   endfunction

   // Column address with A10 and bits beyond the column width cleared
   function automatic logic [ADDR_W-1:0] col_only(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] m;
      m = '0;
      for (int i = 0; i < ADDR_W; i++) begin
         m[i] = (i != AP_BIT) && (i < COL_W + ((i > AP_BIT) ? 1 : 0));
      end
      return a & m;
   endfunction

   logic            busy;
   logic            all_idle;
   logic            bad;
   logic [BA_W-1:0] b;

   always_comb begin
      next_st         = st;
      next_st.illegal = 1'b0;
      next_st.cmd     = dcmd.cmd;
      next_st.bank    = dcmd.bank;
      next_st.addr    = dcmd.addr;
      b               = dcmd.bank;
      busy            = 1'b0;
      bad             = 1'b0;

      // Global timers: refresh, mode load and self-refresh exit
      case (st.mode)
         MODE_REFRESHING, MODE_MRD, MODE_XSNR: begin
            if (st.gcnt == '0) begin
               next_st.mode = MODE_NORMAL;
            end else begin
               next_st.gcnt = st.gcnt - 1'b1;
               busy         = 1'b1;
            end
         end
         default: begin
         end
      endcase

      // Bank timers; a state whose count has run out ends this cycle
      for (int i = 0; i < NBANK; i++) begin
         if (st.bcnt[i] != '0) begin
            next_st.bcnt[i] = st.bcnt[i] - 1'b1;
         end else begin
            case (st.bst[i])
               BANK_ACTIVATING: next_st.bst[i] = BANK_ACTIVE;
               // R15: read burst over, back-to-back access allowed
               // R16: write burst over, back-to-back access allowed
               BANK_READ, BANK_WRITE: next_st.bst[i] = BANK_ACTIVE;
               BANK_READ_AP, BANK_WRITE_AP: begin
                  next_st.bst[i]  = BANK_PRECHARGING;
                  next_st.bcnt[i] = RP_CNT - 1'b1;
               end
               // R13: idle once precharge time is met
               BANK_PRECHARGING: next_st.bst[i] = BANK_IDLE;
               default: begin
               end
            endcase
         end
      end

      all_idle = 1'b1;
      for (int i = 0; i < NBANK; i++) begin
         if (next_st.bst[i] != BANK_IDLE) begin
            all_idle = 1'b0;
         end
      end

      case (next_st.mode)
         MODE_SELF_REF: begin
            if (dcmd.cmd == CMD_CKE_EXIT) begin
               next_st.mode = MODE_XSNR;
               next_st.gcnt = XSNR_CNT - 1'b1;
            end else if (dcmd.cmd != CMD_HOLD) begin
               bad = 1'b1;
            end
         end
         MODE_PDOWN: begin
            // R6: leave power-down on quiet rising enable
            if (dcmd.cmd == CMD_CKE_EXIT) begin
               next_st.mode = MODE_NORMAL;
            end else if (dcmd.cmd != CMD_HOLD) begin
               bad = 1'b1;
            end
         end
         default: begin
            case (dcmd.cmd)
               // R12: nothing changes
               CMD_DESELECT, CMD_NOP: begin
               end
               CMD_MODE_LOAD: begin
                  // R21: all idle only
                  if (all_idle && !busy) begin
                     next_st.mode     = MODE_MRD;
                     next_st.gcnt     = MRD_CNT - 1'b1;
                     // R4: register chosen by bank address
                     next_st.mode_sel = dcmd.bank;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_REFRESH: begin
                  // R21: all idle only
                  if (all_idle && !busy) begin
                     next_st.mode = MODE_REFRESHING;
                     next_st.gcnt = RFC_CNT - 1'b1;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_SELF_REF: begin
                  // R5: self refresh from all idle
                  if (all_idle && !busy) begin
                     next_st.mode = MODE_SELF_REF;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_PD_ENTRY: begin
                  if (!busy) begin
                     next_st.mode = MODE_PDOWN;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_ACTIVATE: begin
                  // R11: idle bank only
                  if (!busy && next_st.bst[b] == BANK_IDLE) begin
                     next_st.bst[b]  = BANK_ACTIVATING;
                     next_st.bcnt[b] = RCD_CNT - 1'b1;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_READ, CMD_READ_AP: begin
                  // R14: column access from row active
                  // R17: a running burst makes the bank non-active
                  if (!busy && can_access(next_st.bst[b])) begin
                     next_st.bst[b]  = (dcmd.cmd == CMD_READ) ? BANK_READ : BANK_READ_AP;
                     next_st.bcnt[b] = BURST_CNT - 1'b1;
                     // R20: unused column bits dropped
                     next_st.addr    = col_only(dcmd.addr);
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_WRITE, CMD_WRITE_AP: begin
                  // R14: column access from row active
                  if (!busy && can_access(next_st.bst[b])) begin
                     next_st.addr = col_only(dcmd.addr);
                     if (dcmd.cmd == CMD_WRITE) begin
                        next_st.bst[b]  = BANK_WRITE;
                        next_st.bcnt[b] = BURST_CNT - 1'b1;
                     end else begin
                        // Write recovery runs before the auto precharge
                        next_st.bst[b]  = BANK_WRITE_AP;
                        next_st.bcnt[b] = BURST_CNT + WR_CNT - 1'b1;
                     end
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_PRECHARGE: begin
                  // R10: addressed bank only
                  if (!busy && can_access(next_st.bst[b])) begin
                     next_st.bst[b]  = BANK_PRECHARGING;
                     next_st.bcnt[b] = RP_CNT - 1'b1;
                  end else begin
                     bad = 1'b1;
                  end
               end
               CMD_PRECHARGE_ALL: begin
                  // R10: every bank, idle ones stay idle
                  for (int i = 0; i < NBANK; i++) begin
                     if (!can_access(next_st.bst[i]) && next_st.bst[i] != BANK_IDLE) begin
                        bad = 1'b1;
                     end
                  end
                  if (busy) begin
                     bad = 1'b1;
                  end
                  if (!bad) begin
                     for (int i = 0; i < NBANK; i++) begin
                        if (can_access(next_st.bst[i])) begin
                           next_st.bst[i]  = BANK_PRECHARGING;
                           next_st.bcnt[i] = RP_CNT - 1'b1;
                        end
                     end
                  end
               end
               // R22: anything else is illegal
               default: bad = 1'b1;
            endcase
         end
      endcase

      // R23: flag it and put mode_sel back; a rejected command makes no bank or mode change of its own
      if (bad) begin
         next_st.illegal  = 1'b1;
         next_st.mode_sel = st.mode_sel;
      end

      next_st.lvl = {next_st.mode == MODE_SELF_REF, next_st.mode == MODE_PDOWN,
                     next_st.mode == MODE_REFRESHING};

      // R2: termination off while in self refresh
      next_st.odt_en = odt && next_st.mode != MODE_SELF_REF;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st.mode     <= MODE_NORMAL;
         st.gcnt     <= '0;
         st.bst      <= {NBANK{BANK_IDLE}};
         st.bcnt     <= '0;
         st.cmd      <= CMD_DESELECT;
         st.bank     <= '0;
         st.addr     <= '0;
         st.mode_sel <= '0;
         st.illegal  <= RST_ILLEGAL;
         st.odt_en   <= RST_ODT_EN;
         st.lvl      <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cmd_code     = st.cmd;
   assign cmd_bank     = st.bank;
   assign cmd_addr     = st.addr;
   assign mode_sel     = st.mode_sel;
   assign illegal      = st.illegal;
   assign odt_en       = st.odt_en;
   assign self_refresh = st.lvl[2];
   assign power_down   = st.lvl[1];
   assign refreshing   = st.lvl[0];
   assign bank_state   = st.bst;

endmodule

// ---- scd_chk.sv ----
// Concurrent checks on the ports of the command decode and bank state block
module scd_chk
   import scd_pkg::*;
#(
   parameter int ADDR_W = 14,
   parameter int COL_W  = 10
) (
   input wire logic                                clk,
   input wire logic                                rst_b,
   input wire logic                                cke,
   input wire logic                                cs_b,
   input wire logic                                ras_b,
   input wire logic                                cas_b,
   input wire logic                                we_b,
   input wire logic [scd_pkg::BA_W-1:0]            ba,
   input wire logic [ADDR_W-1:0]                   addr,
   input wire logic                                odt,
   input wire logic                                use_ba2,
   input wire logic [3:0]                          cmd_code,
   input wire logic [scd_pkg::BA_W-1:0]            cmd_bank,
   input wire logic [ADDR_W-1:0]                   cmd_addr,
   input wire logic [scd_pkg::BA_W-1:0]            mode_sel,
   input wire logic                                illegal,
   input wire logic                                odt_en,
   input wire logic                                self_refresh,
   input wire logic                                power_down,
   input wire logic                                refreshing,
   input wire logic [scd_pkg::NBANK-1:0][2:0]      bank_state
);
   logic [NBANK-1:0][2:0] prev_bs;

   // Bank states as they stood before the command now shown was sampled
   always_ff @(posedge clk) begin
      prev_bs <= bank_state;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_deselect_quiet: assert property (
      $past(rst_b) && cke && $past(cke) && cs_b |=> cmd_code == 4'h0)
      else $error("deselect not decoded as deselect");
   a_read_decode: assert property (
      $past(rst_b) && cke && $past(cke) && !cs_b && ras_b && !cas_b && we_b
      |=> cmd_code == ($past(addr[AP_BIT]) ? 4'h9 : 4'h8))
      else $error("read decoded wrongly");
   a_write_decode: assert property (
      $past(rst_b) && cke && $past(cke) && !cs_b && ras_b && !cas_b && !we_b
      |=> cmd_code == ($past(addr[AP_BIT]) ? 4'hb : 4'ha))
      else $error("write decoded wrongly");
   a_act_opens: assert property (
      cmd_code == 4'h7 && !illegal
      |-> bank_state[cmd_bank] == 3'h1 && prev_bs[cmd_bank] inside {3'h0, 3'h7})
      else $error("activate accepted on a busy bank or did not open");
   a_burst_whole: assert property (
      cmd_code == 4'h8 && !illegal
      |-> bank_state[cmd_bank] == 3'h3 ##1 bank_state[$past(cmd_bank)] == 3'h3)
      else $error("read burst cut short");
   a_refresh_idle: assert property (
      cmd_code == 4'h3 && !illegal |-> refreshing && prev_bs == '0)
      else $error("refresh accepted with a bank open");
   a_odt_path: assert property (
      odt_en |-> $past(odt))
      else $error("termination enabled without request");
   a_odt_sr_off: assert property (
      self_refresh && $past(self_refresh) |-> !odt_en)
      else $error("termination on during self refresh");
   a_pd_exit: assert property (
      power_down && cke && (cs_b || (ras_b && cas_b && we_b)) |=> !power_down)
      else $error("power-down not left on clock enable");
   a_bank_fold: assert property (
      !use_ba2 |-> !cmd_bank[2])
      else $error("third bank bit used while strapped off");
endmodule

// ---- scd_ctl_model.sv ----
// Controller-side model that drives the command and address pins
module scd_ctl_model #(
   parameter int ADDR_W = 14
) (
   input  wire logic                        clk,
   output logic                             cke,
   output logic                             cs_b,
   output logic                             ras_b,
   output logic                             cas_b,
   output logic                             we_b,
   output logic      [scd_pkg::BA_W-1:0]    ba,
   output logic      [ADDR_W-1:0]           addr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cke = 1'b1;
      {cs_b, ras_b, cas_b, we_b} = 4'h7;
      ba = '0;
      addr = '0;
   end

   // only what the bench orders, one command held for one whole edge
   task automatic issue(input logic k, input logic [3:0] p, input logic [2:0] b,
                        input logic [ADDR_W-1:0] a);
      cke = k;
      cs_b = p[3];
      // Unselected lines flip so a stale value can never pass for a good one
      {ras_b, cas_b, we_b} = p[3] ? ~{ras_b, cas_b, we_b} : p[2:0];
      ba = p[3] ? ~ba : b;
      addr = p[3] ? ~addr : a;
      @(posedge clk);
      #1;
   endtask
endmodule

// ---- test_sdram_command_decode_bank_state.sv ----
// Self-checking bench for the command decode and bank state block
module test_sdram_command_decode_bank_state;
   import scd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] P_NOP = 4'h7, P_DES = 4'hf, P_ACT = 4'h3, P_RD = 4'h5;
   localparam logic [3:0] P_WR = 4'h4, P_PRE = 4'h2, P_REF = 4'h1, P_MRS = 4'h0;

   logic                      clk, rst_b, odt, use_ba2;
   logic                      cke, cs_b, ras_b, cas_b, we_b;
   logic [BA_W-1:0]           ba, cmd_bank, mode_sel;
   logic [13:0]               addr, cmd_addr;
   logic [3:0]                cmd_code;
   logic                      illegal, odt_en, self_refresh, power_down, refreshing;
   logic [NBANK-1:0][2:0]     bank_state;
   int                        n_errors = 0;
   int                        comparisons = 0;
   int                        cycles = 0;

   always #20 clk = ~clk;

   scd_ctl_model #(.ADDR_W(14)) u_ctl (.*);

   scd_top #(.ADDR_W(14), .COL_W(10)) u_dut (.*);

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // The whole run needs about 90 cycles; far beyond that means a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic go(input logic [3:0] p, input logic [2:0] b = 3'h0,
                     input logic [13:0] a = 14'h0000);
      u_ctl.issue(1'b1, p, b, a);
   endtask

   // Clock enable sampled low
   task automatic lo(input logic [3:0] p);
      u_ctl.issue(1'b0, p, 3'h0, 14'h0000);
   endtask

   task automatic nop(input int n);
      repeat (n) go(P_NOP);
   endtask

   task automatic t_walk();
      odt = 1'b1;
      go(P_ACT, 3'h1, 14'h0155);
      chk("act code", 4'h7, cmd_code);
      chk("act state", 3'h1, bank_state[1]);
      go(P_RD, 3'h1, 14'h3bff);
      chk("rd code", 4'h8, cmd_code);
      chk("rd column", 14'h03ff, cmd_addr);
      chk("rd state", 3'h3, bank_state[1]);
      go(P_RD, 3'h1);
      chk("cut burst flag", 1'b1, illegal);
      chk("burst held", 3'h3, bank_state[1]);
      go(P_DES);
      chk("deselect code", 4'h0, cmd_code);
      chk("burst end", 3'h2, bank_state[1]);
      chk("odt delay", 1'b1, odt_en);
      go(P_PRE, 3'h1);
      chk("pre state", 3'h7, bank_state[1]);
      nop(1);
      chk("idle again", 3'h0, bank_state[1]);
      odt = 1'b0;
   endtask

   task automatic t_illegal();
      go(P_RD, 3'h4);
      chk("rd idle flag", 1'b1, illegal);
      chk("rd idle state", 3'h0, bank_state[4]);
      go(P_PRE, 3'h4);
      chk("pre idle flag", 1'b1, illegal);
      nop(1);
      chk("flag pulse", 1'b0, illegal);
   endtask

   task automatic t_write();
      use_ba2 = 1'b0;
      go(P_ACT, 3'h6);
      chk("bank fold", 3'h2, cmd_bank);
      chk("fold state", 3'h1, bank_state[2]);
      go(P_WR, 3'h2);
      chk("wr code", 4'ha, cmd_code);
      chk("wr state", 3'h4, bank_state[2]);
      nop(1);
      go(P_RD, 3'h2);
      chk("wr then rd", 3'h3, bank_state[2]);
      nop(1);
      go(P_WR, 3'h2, 14'h0400);
      chk("wr ap code", 4'hb, cmd_code);
      chk("rd then wr", 3'h6, bank_state[2]);
      nop(8);
      chk("wr ap closes", 3'h0, bank_state[2]);
      use_ba2 = 1'b1;
   endtask

   task automatic t_prea();
      go(P_ACT);
      nop(1);
      go(P_ACT, 3'h5);
      nop(1);
      go(P_PRE, 3'h3, 14'h0400);
      chk("pre all code", 4'h6, cmd_code);
      chk("pre all b0", 3'h7, bank_state[0]);
      chk("pre all b5", 3'h7, bank_state[5]);
      chk("pre all b3", 3'h0, bank_state[3]);
      nop(1);
      chk("all idle", 24'h0, bank_state);
   endtask

   task automatic t_refresh();
      go(P_ACT, 3'h1);
      nop(1);
      go(P_REF);
      chk("ref open bank", 1'b1, illegal);
      go(P_PRE, 3'h1);
      nop(1);
      go(P_REF);
      chk("ref code", 4'h3, cmd_code);
      chk("ref busy", 1'b1, refreshing);
      go(P_ACT);
      chk("act in ref", 1'b1, illegal);
      nop(6);
      chk("ref done", 1'b0, refreshing);
      go(P_MRS, 3'h5, 14'h0123);
      chk("mrs code", 4'h2, cmd_code);
      nop(3);
      chk("mrs select", 3'h5, mode_sel);
   endtask

   task automatic t_self();
      odt = 1'b1;
      lo(P_REF);
      chk("sr entry", 1'b1, self_refresh);
      lo(P_NOP);
      chk("odt off sr", 1'b0, odt_en);
      go(P_NOP);
      chk("sr exit", 1'b0, self_refresh);
      go(P_ACT);
      chk("act in exit", 1'b1, illegal);
      nop(6);
      go(P_ACT);
      chk("act after exit", 1'b0, illegal);
      nop(1);
      go(P_PRE);
      nop(1);
      odt = 1'b0;
   endtask

   task automatic t_pdown();
      go(P_ACT, 3'h3);
      nop(1);
      // power-down held two cycles, well inside any refresh interval
      lo(P_NOP);
      chk("pd entry", 1'b1, power_down);
      lo(P_DES);
      chk("pd bank kept", 3'h2, bank_state[3]);
      go(P_NOP);
      chk("pd exit", 1'b0, power_down);
      go(P_RD, 3'h3, 14'h0400);
      chk("rd ap code", 4'h9, cmd_code);
      chk("rd ap state", 3'h5, bank_state[3]);
      nop(6);
      chk("rd ap idle", 3'h0, bank_state[3]);
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      odt = 1'b0;
      use_ba2 = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      chk("reset banks", 24'h0, bank_state);
      chk("reset code", 4'h0, cmd_code);
      rst_b = 1'b1;
      // The first sample after release reads as a clock-enable exit
      nop(2);
      t_walk();
      t_illegal();
      t_write();
      t_prea();
      t_refresh();
      t_self();
      t_pdown();
      stop_test();
   end
endmodule

bind scd_top scd_chk #(.ADDR_W(ADDR_W), .COL_W(COL_W)) u_chk (.*);
